// ===== pgs_coef_resolve.sv
// Resolves the active proportional band, integral and derivative time
`timescale 1ns/100ps
module pgs_coef_resolve (
	// Settings
	input wire pgs_pkg::pgs_val_t coef_i [pgs_pkg::NUM_COEF],
	// Selection
	input wire logic [1:0] set_i,
	input wire logic below_i,
	// Result
	output pgs_pkg::pgs_coef_s coef_o
);

	pgs_pkg::pgs_val_t res [3];

	// Walk the fall-back chain for each coefficient kind
	always_comb begin
		pgs_pkg::pgs_val_t base;
		pgs_pkg::pgs_val_t neg1;
		pgs_pkg::pgs_val_t pos_s;
		pgs_pkg::pgs_val_t neg_s;
		base = '0;
		neg1 = '0;
		pos_s = '0;
		neg_s = '0;
		for (int k = 0; k < 3; k++) begin
			base = coef_i[pgs_pkg::coef_index(2'b00, 1'b0, 2'(k))];
			neg1 = pgs_pkg::pick(coef_i[pgs_pkg::coef_index(2'b00, 1'b1, 2'(k))], base);
			pos_s = coef_i[pgs_pkg::coef_index(set_i, 1'b0, 2'(k))];
			neg_s = coef_i[pgs_pkg::coef_index(set_i, 1'b1, 2'(k))];
			if (set_i == 2'b00) begin
				res[k] = below_i ? neg1 : base;
			end else if (below_i) begin
				// negative takes own positive, then first negative
				res[k] = pgs_pkg::pick(neg_s, pgs_pkg::pick(pos_s, neg1));
			end else begin
				// positive falls back to first set
				res[k] = pgs_pkg::pick(pos_s, base);
			end
		end
	end

	assign coef_o.pb = res[0];
	assign coef_o.ti = res[1];
	assign coef_o.td = res[2];

endmodule

// ===== pgs_dev_gain.sv
// Deviation-dependent gain factor G from breakpoints and gain settings
`timescale 1ns/100ps
module pgs_dev_gain (
	// Settings
	input wire pgs_pkg::pgs_val_t point_i [pgs_pkg::NUM_BP],
	input wire pgs_pkg::pgs_val_t gain_i [pgs_pkg::NUM_GAIN],
	// Loop input
	input wire pgs_pkg::pgs_val_t dev_i,
	// Result
	output pgs_pkg::pgs_val_t gain_o,
	output logic sw_en_o
);

	// Linear interpolation; the span is never zero where it is called
	function automatic pgs_pkg::pgs_val_t lerp(input pgs_pkg::pgs_val_t x,
			input pgs_pkg::pgs_val_t x0, input pgs_pkg::pgs_val_t x1,
			input pgs_pkg::pgs_val_t y0, input pgs_pkg::pgs_val_t y1);
		logic signed [16:0] dy;
		logic signed [16:0] dx;
		logic signed [16:0] span;
		logic signed [33:0] prod;
		logic signed [33:0] q;
		dy = $signed({1'b0, y1}) - $signed({1'b0, y0});
		dx = $signed({1'b0, x}) - $signed({1'b0, x0});
		span = $signed({1'b0, x1}) - $signed({1'b0, x0});
		prod = dy * dx;
		// Both operands stay signed so a falling slope truncates toward zero
		q = prod / 34'(span);
		return 16'(q + $signed({18'h00000, y0}));
	endfunction

	pgs_pkg::pgs_val_t g [pgs_pkg::NUM_GAIN];
	wire pgs_pkg::pgs_val_t pa = point_i[pgs_pkg::BP_A];
	wire pgs_pkg::pgs_val_t pb = point_i[pgs_pkg::BP_B];
	wire pgs_pkg::pgs_val_t pc1 = point_i[pgs_pkg::BP_C1];
	wire pgs_pkg::pgs_val_t pc2 = point_i[pgs_pkg::BP_C2];

	// switching needs both inner points set
	assign sw_en_o = (pc1 != pgs_pkg::SENTINEL) && (pc2 != pgs_pkg::SENTINEL);

	always_comb begin
		for (int i = 0; i < pgs_pkg::NUM_GAIN; i++) begin
			g[i] = pgs_pkg::pick(gain_i[i], pgs_pkg::GAIN_UNITY);
		end
	end

	// Segment choice from the top breakpoint down
	always_comb begin
		if (!sw_en_o) begin
			gain_o = pgs_pkg::GAIN_UNITY;
		// hold A beyond the top point
		end else if (dev_i >= pa) begin
			gain_o = g[pgs_pkg::BP_A];
		end else if (dev_i > pc1) begin
			gain_o = lerp(dev_i, pc1, pa, g[pgs_pkg::BP_C1], g[pgs_pkg::BP_A]);
		// coincident inner points take the larger gain
		end else if ((dev_i == pc1) && (dev_i == pc2)) begin
			gain_o = (g[pgs_pkg::BP_C1] > g[pgs_pkg::BP_C2]) ? g[pgs_pkg::BP_C1] :
				g[pgs_pkg::BP_C2];
		end else if (dev_i == pc1) begin
			gain_o = g[pgs_pkg::BP_C1];
		// gain D inside the inner band
		end else if (dev_i > pc2) begin
			gain_o = g[pgs_pkg::GN_D];
		end else if (dev_i == pc2) begin
			gain_o = g[pgs_pkg::BP_C2];
		end else if (dev_i > pb) begin
			gain_o = lerp(dev_i, pb, pc2, g[pgs_pkg::BP_B], g[pgs_pkg::BP_C2]);
		end else begin
			gain_o = g[pgs_pkg::BP_B];
		end
	end

endmodule

// ===== pgs_gain_selector.sv
// PID gain selector top: registers, select pins, coefficient and gain outputs
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
module pgs_gain_selector (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Gain select terminals
	input wire logic gain_select_low_i,
	input wire logic gain_select_high_i,
	// Loop inputs, same clock
	input wire pgs_pkg::pgs_val_t deviation_i,
	input wire logic below_setpoint_i,
	// Loop outputs
	output pgs_pkg::pgs_out_s coef_o,
	output logic [1:0] active_set_o,
	output logic irq_o
);

	// ==========================================================
	// Storage
	pgs_pkg::pgs_val_t coef_q [pgs_pkg::NUM_COEF];
	pgs_pkg::pgs_val_t bp_q [pgs_pkg::NUM_BP];
	pgs_pkg::pgs_val_t gain_q [pgs_pkg::NUM_GAIN];
	logic [pgs_pkg::ST_W-1:0] status_q;
	logic [pgs_pkg::ST_W-1:0] mask_q;
	logic [1:0] sel_meta;
	logic [1:0] sel_sync;
	logic [1:0] sel_prev;
	logic below_prev;
	logic [31:0] rdata_q;
	pgs_pkg::pgs_out_s out_q;

	// ==========================================================
	// Address decode
	wire logic [5:0] word_idx = reg_addr_i[7:2];
	wire logic aligned = reg_addr_i[1:0] == 2'b00;
	wire pgs_pkg::pgs_val_t wval = reg_wdata_i[15:0];
	wire logic upper_zero = reg_wdata_i[31:16] == 16'h0000;
	wire logic [5:0] coef_word = 6'(pgs_pkg::OFS_COEF_BASE >> 2);
	wire logic [5:0] dev_word = 6'(pgs_pkg::OFS_DEV_BASE >> 2);
	wire logic [5:0] gain_word = 6'(pgs_pkg::OFS_GAIN_BASE >> 2);
	wire logic hit_coef = aligned && (word_idx >= coef_word) &&
		(word_idx < coef_word + 6'(pgs_pkg::NUM_COEF));
	wire logic hit_bp = aligned && (word_idx >= dev_word) &&
		(word_idx < dev_word + 6'(pgs_pkg::NUM_BP));
	wire logic hit_gain = aligned && (word_idx >= gain_word) &&
		(word_idx < gain_word + 6'(pgs_pkg::NUM_GAIN));
	wire logic [4:0] coef_idx = 5'(word_idx - coef_word);
	wire logic [1:0] bp_idx = 2'(word_idx - dev_word);
	wire logic [2:0] gain_idx = 3'(word_idx - gain_word);
	wire logic [1:0] coef_kind = 2'(coef_idx % 5'd3);
	wire logic coef_is_base = coef_idx < 5'd3;
	wire logic hit_status = reg_addr_i == pgs_pkg::OFS_STATUS;
	wire logic hit_mask = reg_addr_i == pgs_pkg::OFS_MASK;

	// ==========================================================
	// Write validation
	// band and time ranges, sentinel outside the base set
	wire logic coef_val_ok = upper_zero && pgs_pkg::coef_ok(coef_kind, wval, coef_is_base);
	wire logic gain_val_ok = upper_zero && ((wval == pgs_pkg::SENTINEL) ||
		pgs_pkg::in_range(wval, pgs_pkg::GAIN_MIN, pgs_pkg::GAIN_MAX));
	wire logic a_ok = pgs_pkg::in_range(wval, pgs_pkg::DEV_A_MIN, pgs_pkg::DEV_A_MAX);
	wire logic b_ok = pgs_pkg::in_range(wval, pgs_pkg::DEV_B_MIN, pgs_pkg::DEV_B_MAX);
	wire logic c_ok = (wval == pgs_pkg::SENTINEL) ||
		pgs_pkg::in_range(wval, pgs_pkg::DEV_C_MIN, pgs_pkg::DEV_C_MAX);
	wire logic bp_range_ok = upper_zero && ((bp_idx == 2'(pgs_pkg::BP_A)) ? a_ok :
		(bp_idx == 2'(pgs_pkg::BP_B)) ? b_ok : c_ok);
	// Candidate set as it would stand after the write
	wire pgs_pkg::pgs_val_t cand_a = (bp_idx == 2'(pgs_pkg::BP_A)) ? wval : bp_q[pgs_pkg::BP_A];
	wire pgs_pkg::pgs_val_t cand_b = (bp_idx == 2'(pgs_pkg::BP_B)) ? wval : bp_q[pgs_pkg::BP_B];
	wire pgs_pkg::pgs_val_t cand_c1 = (bp_idx == 2'(pgs_pkg::BP_C1)) ? wval :
		bp_q[pgs_pkg::BP_C1];
	wire pgs_pkg::pgs_val_t cand_c2 = (bp_idx == 2'(pgs_pkg::BP_C2)) ? wval :
		bp_q[pgs_pkg::BP_C2];
	// ordering is checked against the whole candidate set
	wire logic bp_order = pgs_pkg::bp_order_ok(cand_a, cand_b, cand_c1, cand_c2);
	wire logic wr_coef_ok = reg_wr_i && hit_coef && coef_val_ok;
	wire logic wr_bp_ok = reg_wr_i && hit_bp && bp_range_ok && bp_order;
	wire logic wr_gain_ok = reg_wr_i && hit_gain && gain_val_ok;
	// Rejected writes leave the setting untouched and raise the error flag
	wire logic wr_reject = reg_wr_i && ((hit_coef && !coef_val_ok) ||
		(hit_bp && !(bp_range_ok && bp_order)) || (hit_gain && !gain_val_ok));

	// ==========================================================
	// Coefficient settings; base band resets to a usable value
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < pgs_pkg::NUM_COEF; i++) begin
				coef_q[i] <= pgs_pkg::SENTINEL;
			end
			coef_q[0] <= pgs_pkg::RST_BASE_PB;
		end else if (wr_coef_ok) begin
			coef_q[coef_idx] <= wval;
		end
	end

	// Breakpoints
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bp_q[pgs_pkg::BP_A] <= pgs_pkg::RST_DEV_A;
			bp_q[pgs_pkg::BP_B] <= pgs_pkg::RST_DEV_B;
			bp_q[pgs_pkg::BP_C1] <= pgs_pkg::SENTINEL;
			bp_q[pgs_pkg::BP_C2] <= pgs_pkg::SENTINEL;
		end else if (wr_bp_ok) begin
			bp_q[bp_idx] <= wval;
		end
	end

	// Deviation gains
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < pgs_pkg::NUM_GAIN; i++) begin
				gain_q[i] <= pgs_pkg::SENTINEL;
			end
		end else if (wr_gain_ok) begin
			gain_q[gain_idx] <= wval;
		end
	end

	// ==========================================================
	// Select terminal synchroniser; pins are asynchronous to the clock
	// terminals arrive already routed to the two select functions
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_meta <= 2'b00;
			sel_sync <= 2'b00;
		end else begin
			sel_meta <= {gain_select_high_i, gain_select_low_i};
			sel_sync <= sel_meta;
		end
	end

	// ==========================================================
	// Coefficient and gain datapath
	pgs_pkg::pgs_coef_s coef_sel;
	pgs_pkg::pgs_val_t gain_g;
	logic sw_en;

	// high pin is the upper set bit, low pin the lower
	pgs_coef_resolve u_resolve (
		.coef_i(coef_q),
		.set_i(sel_sync),
		.below_i(below_setpoint_i),
		.coef_o(coef_sel)
	);

	pgs_dev_gain u_dev_gain (
		.point_i(bp_q),
		.gain_i(gain_q),
		.dev_i(deviation_i),
		.gain_o(gain_g),
		.sw_en_o(sw_en)
	);

	// combined gain G/band, scaled so unity reads as the scale value
	wire logic [31:0] loop_num = 32'(gain_g) * pgs_pkg::LOOP_SCALE;
	wire logic [23:0] loop_gain = 24'(loop_num / 32'(coef_sel.pb));

	// Outputs are registered so downstream sees one consistent set
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_q <= '0;
		end else begin
			out_q.coef <= coef_sel;
			out_q.gain_g <= gain_g;
			out_q.loop_gain <= loop_gain;
		end
	end

	// ==========================================================
	// Events and interrupt
	wire logic ev_setchg = sel_sync != sel_prev;
	wire logic ev_polchg = below_setpoint_i != below_prev;
	wire logic [pgs_pkg::ST_W-1:0] events = {ev_polchg, ev_setchg, wr_reject};
	wire logic rd_status = reg_rd_i && hit_status;

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_prev <= 2'b00;
			below_prev <= 1'b0;
		end else begin
			sel_prev <= sel_sync;
			below_prev <= below_setpoint_i;
		end
	end

	// Read clears, but a fresh event in the same cycle still lands
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			status_q <= '0;
		end else if (rd_status) begin
			status_q <= events;
		end else begin
			status_q <= status_q | events;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mask_q <= '0;
		end else if (reg_wr_i && hit_mask) begin
			mask_q <= reg_wdata_i[pgs_pkg::ST_W-1:0];
		end
	end

	// ==========================================================
	// Read mux; unmapped addresses read zero
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_coef) begin
			rd_word = {16'h0000, coef_q[coef_idx]};
		end else if (hit_bp) begin
			rd_word = {16'h0000, bp_q[bp_idx]};
		end else if (hit_gain) begin
			rd_word = {16'h0000, gain_q[gain_idx]};
		end else if (hit_status) begin
			rd_word = {29'h0000_0000, status_q};
		end else if (hit_mask) begin
			rd_word = {29'h0000_0000, mask_q};
		end else if (reg_addr_i == pgs_pkg::OFS_GAIN_G) begin
			rd_word = {15'h0000, sw_en, out_q.gain_g};
		end else if (reg_addr_i == pgs_pkg::OFS_LOOP) begin
			rd_word = {8'h00, out_q.loop_gain};
		end else if (reg_addr_i == pgs_pkg::OFS_ACTIVE) begin
			rd_word = {29'h0000_0000, below_setpoint_i, sel_sync};
		end
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= reg_rd_i ? rd_word : 32'h0000_0000;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign coef_o = out_q;
	assign active_set_o = sel_sync;
	assign irq_o = |(status_q & mask_q);

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);

	chk_first_set_pos: assert property (
		(sel_sync == 2'b00) && !below_setpoint_i |=> coef_o.coef.pb == $past(coef_q[0]))
		else $error("first set positive band not applied");

	chk_first_neg_fallback: assert property (
		(sel_sync == 2'b00) && below_setpoint_i && (coef_q[3] == pgs_pkg::SENTINEL)
		|=> coef_o.coef.pb == $past(coef_q[0]))
		else $error("first negative band did not fall back");

	chk_set_pos_fallback: assert property (
		(sel_sync == 2'b01) && !below_setpoint_i && (coef_q[7] == pgs_pkg::SENTINEL)
		|=> coef_o.coef.ti == $past(coef_q[1]))
		else $error("second set integral did not fall back");

	chk_set_neg_fallback: assert property (
		(sel_sync == 2'b10) && below_setpoint_i && (coef_q[15] == pgs_pkg::SENTINEL) &&
		(coef_q[12] != pgs_pkg::SENTINEL) |=> coef_o.coef.pb == $past(coef_q[12]))
		else $error("third set negative band did not take positive");

	chk_pin_to_set: assert property (
		$changed({gain_select_high_i, gain_select_low_i}) && $stable(sel_sync)
		|-> ##2 active_set_o == $past({gain_select_high_i, gain_select_low_i}, 2) ||
		$changed(sel_meta))
		else $error("select pins not reflected after two edges");

	chk_unity_disabled: assert property (
		!sw_en |=> coef_o.gain_g == pgs_pkg::GAIN_UNITY)
		else $error("gain not unity while switching is off");

	chk_order_reject: assert property (
		reg_wr_i && hit_bp && !bp_order
		|=> $stable(bp_q[pgs_pkg::BP_A]) && $stable(bp_q[pgs_pkg::BP_C1]) &&
		status_q[pgs_pkg::ST_WERR])
		else $error("bad breakpoint order accepted");

	chk_equal_points_max: assert property (
		sw_en && (bp_q[pgs_pkg::BP_C1] == bp_q[pgs_pkg::BP_C2]) &&
		(deviation_i == bp_q[pgs_pkg::BP_C1]) && (gain_q[pgs_pkg::BP_C1] != pgs_pkg::SENTINEL) &&
		(gain_q[pgs_pkg::BP_C2] != pgs_pkg::SENTINEL) |=> coef_o.gain_g >=
		$past(gain_q[pgs_pkg::BP_C1]) && coef_o.gain_g >= $past(gain_q[pgs_pkg::BP_C2]))
		else $error("equal points did not take larger gain");

	chk_loop_product: assert property (
		coef_o.coef.pb != 16'h0000 |-> coef_o.loop_gain ==
		24'((32'(coef_o.gain_g) * pgs_pkg::LOOP_SCALE) / 32'(coef_o.coef.pb)))
		else $error("loop gain does not match G over band");

	chk_point_a_range: assert property (
		pgs_pkg::in_range(bp_q[pgs_pkg::BP_A], pgs_pkg::DEV_A_MIN, pgs_pkg::DEV_A_MAX))
		else $error("point A left its range");

	chk_irq_level: assert property (
		irq_o == |(status_q & mask_q))
		else $error("interrupt level wrong");

	chk_status_clear: assert property (
		rd_status && !(|events) |=> status_q == '0)
		else $error("status not cleared by read");

	// gain D between split inner points
	chk_inner_band_d: assert property (
		sw_en && (deviation_i > bp_q[pgs_pkg::BP_C2]) && (deviation_i < bp_q[pgs_pkg::BP_C1])
		|=> coef_o.gain_g == pgs_pkg::pick($past(gain_q[pgs_pkg::GN_D]), pgs_pkg::GAIN_UNITY))
		else $error("inner band did not take gain D");

	cov_fourth_set_neg: cover property (
		(sel_sync == 2'b11) && below_setpoint_i);
	cov_order_reject: cover property (
		reg_wr_i && hit_bp && !bp_order);
	cov_switch_active: cover property (
		sw_en && (deviation_i > bp_q[pgs_pkg::BP_C2]) && (deviation_i < bp_q[pgs_pkg::BP_C1]));
	cov_irq_raised: cover property (
		$rose(irq_o));

endmodule

// ===== pgs_pkg.sv
// Constants, types and helper functions shared by the PID gain selector files
// What this block does
// - Below set point, use first-set negative coefficients; sentinel falls back to positive.
// - Select pins pick set: none first, low second, high third, both fourth.
// - Sentinel positive coefficient of sets two to four takes the first-set value.
// - Sentinel negative coefficient of sets two to four takes that set's positive one, or the first-set negative one if that is sentinel too.
// - Loop gain is G times Kp, Kp being the reciprocal of the band.
// - A deviation gain holding the sentinel acts as 100 percent.
// - Gain switching works only when both C1 and C2 points are not sentinel.
// - Breakpoint writes break unless A above C1, C1 not below C2, C2 above B.
// - With C1 equal to C2, the larger of gains C1 and C2 applies.
// - Point A accepts 400.1 to 600 percent, resets to 600 percent.
// - Point B accepts 400 to 599.9 percent, resets to 400 percent.
// - Points C1 and C2 accept up to 599.9 percent or sentinel, reset sentinel.
// - Gain D covers deviations between C1 and C2; other gains sit at their points.
// - Each deviation gain accepts 0.1 to 1000 percent or the sentinel.
// - Bands 0.1 to 1000 percent, derivative 0.01 to 10 s, sentinel allowed outside the first positive set and reset except its band.
package pgs_pkg;

	// ==========================================================
	// Value coding
	typedef logic [15:0] pgs_val_t;
	localparam pgs_val_t SENTINEL = 16'hFFFF;   // Fall-back marker
	localparam pgs_val_t PB_MIN = 16'h0001;     // 0.1 percent steps
	localparam pgs_val_t PB_MAX = 16'h2710;
	localparam pgs_val_t TI_MIN = 16'h0001;     // 0.1 s steps
	localparam pgs_val_t TI_MAX = 16'h8CA0;
	localparam pgs_val_t TD_MIN = 16'h0001;     // 0.01 s steps
	localparam pgs_val_t TD_MAX = 16'h03E8;
	localparam pgs_val_t GAIN_MIN = 16'h0001;
	localparam pgs_val_t GAIN_MAX = 16'h2710;
	localparam pgs_val_t GAIN_UNITY = 16'h03E8; // 100.0 percent
	localparam pgs_val_t DEV_A_MIN = 16'h0FA1;
	localparam pgs_val_t DEV_A_MAX = 16'h1770;
	localparam pgs_val_t DEV_B_MIN = 16'h0FA0;
	localparam pgs_val_t DEV_B_MAX = 16'h176F;
	localparam pgs_val_t DEV_C_MIN = 16'h0FA1;
	localparam pgs_val_t DEV_C_MAX = 16'h176F;
	localparam pgs_val_t RST_DEV_A = 16'h1770;
	localparam pgs_val_t RST_DEV_B = 16'h0FA0;
	localparam pgs_val_t RST_BASE_PB = 16'h03E8;
	localparam logic [31:0] LOOP_SCALE = 32'h0000_03E8;

	// ==========================================================
	// Register map (byte addresses, one word each)
	localparam int NUM_COEF = 24;
	localparam int NUM_BP = 4;
	localparam int NUM_GAIN = 5;
	localparam logic [7:0] OFS_COEF_BASE = 8'h00;
	localparam logic [7:0] OFS_DEV_BASE = 8'h60;
	localparam logic [7:0] OFS_GAIN_BASE = 8'h70;
	localparam logic [7:0] OFS_STATUS = 8'h84;
	localparam logic [7:0] OFS_MASK = 8'h88;
	localparam logic [7:0] OFS_GAIN_G = 8'h8C;
	localparam logic [7:0] OFS_LOOP = 8'h90;
	localparam logic [7:0] OFS_ACTIVE = 8'h94;
	localparam int BP_A = 0;
	localparam int BP_B = 1;
	localparam int BP_C1 = 2;
	localparam int BP_C2 = 3;
	localparam int GN_D = 4;
	localparam int ST_W = 3;
	localparam int ST_WERR = 0;
	localparam int ST_SETCHG = 1;
	localparam int ST_POLCHG = 2;

	typedef enum logic [1:0] {
		KIND_PB = 2'b00,
		KIND_TI = 2'b01,
		KIND_TD = 2'b10
	} pgs_kind_e;

	typedef struct packed {
		pgs_val_t pb;
		pgs_val_t ti;
		pgs_val_t td;
	} pgs_coef_s;

	typedef struct packed {
		pgs_coef_s coef;
		pgs_val_t gain_g;
		logic [23:0] loop_gain;
	} pgs_out_s;

	// ==========================================================
	// Helpers
	function automatic pgs_val_t pick(input pgs_val_t v, input pgs_val_t fb);
		return (v == SENTINEL) ? fb : v;
	endfunction

	function automatic logic in_range(input pgs_val_t v, input pgs_val_t lo, input pgs_val_t hi);
		return (v >= lo) && (v <= hi);
	endfunction

	function automatic logic [4:0] coef_index(input logic [1:0] set, input logic pol,
			input logic [1:0] kind);
		return 5'(set * 6 + pol * 3 + kind);
	endfunction

	// Base set cannot fall back, so it refuses the sentinel
	function automatic logic coef_ok(input logic [1:0] kind, input pgs_val_t v, input logic base);
		if (v == SENTINEL) begin
			return !base;
		end
		case (kind)
			KIND_PB: return in_range(v, PB_MIN, PB_MAX);
			KIND_TI: return in_range(v, TI_MIN, TI_MAX);
			default: return in_range(v, TD_MIN, TD_MAX);
		endcase
	endfunction

	function automatic logic bp_order_ok(input pgs_val_t a, input pgs_val_t b,
			input pgs_val_t c1, input pgs_val_t c2);
		logic ok;
		ok = a > b;
		if (c1 != SENTINEL) begin
			ok = ok && (a > c1) && (c1 > b);
		end
		if (c2 != SENTINEL) begin
			ok = ok && (a > c2) && (c2 > b);
		end
		if ((c1 != SENTINEL) && (c2 != SENTINEL)) begin
			ok = ok && (c1 >= c2);
		end
		return ok;
	endfunction

endpackage

// ===== pgs_term_model.sv
// Input terminal model routing two terminals to the gain select pins
`timescale 1ns/100ps
module pgs_term_model (
	// Terminal function codes and levels
	input wire logic [7:0] func_a_i,
	input wire logic [7:0] func_b_i,
	input wire logic lvl_a_i,
	input wire logic lvl_b_i,
	// Select pins
	output logic gain_select_low_o,
	output logic gain_select_high_o
);
	// ======================================
	// Routing
	localparam logic [7:0] FN_LOW = 8'h78;
	localparam logic [7:0] FN_HIGH = 8'h79;
	// An unassigned terminal drives no select function
	// routing by function code
	assign gain_select_low_o = (func_a_i == FN_LOW && lvl_a_i) || (func_b_i == FN_LOW && lvl_b_i);
	assign gain_select_high_o = (func_a_i == FN_HIGH && lvl_a_i) || (func_b_i == FN_HIGH && lvl_b_i);
endmodule

// ===== test_pgs_gain_selector.sv
// Self-checking bench for the PID gain selector
`timescale 1ns/100ps
module test_pgs_gain_selector;
	// ======================================
	// Signals
	logic sys_clk = 0, resetn = 0, wr = 0, rd = 0, la = 0, lb = 0, below = 0, sl, sh;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, got, exp_g;
	pgs_pkg::pgs_val_t dev = 16'h0000, pb1, pb2, pbn, exp_pb, tdb, tin, exp_neg;
	pgs_pkg::pgs_out_s coef;
	logic [1:0] act;
	logic irq;
	int n_mismatch = 0, num_checks = 0, seed = 50;

	// Clock at 10 MHz
	always #50 sys_clk = ~sys_clk;

	pgs_term_model i_term (.func_a_i(8'h78), .func_b_i(8'h79), .lvl_a_i(la), .lvl_b_i(lb),
		.gain_select_low_o(sl), .gain_select_high_o(sh));
	pgs_gain_selector i_dut (.sys_clk_i(sys_clk), .resetn_i(resetn), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.gain_select_low_i(sl), .gain_select_high_i(sh), .deviation_i(dev),
		.below_setpoint_i(below), .coef_o(coef), .active_set_o(act), .irq_o(irq));

	// ======================================
	// Tasks
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= {16'h0000, d};
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	function automatic logic [23:0] exp_loop(input logic [31:0] g, input logic [31:0] pb);
		return 24'(g * 1000 / pb);
	endfunction

	// Straight line between two breakpoints, truncated toward zero
	function automatic logic [31:0] exp_lerp(input int x, input int x0, input int x1,
			input int y0, input int y1);
		return 32'(y0 + (y1 - y0) * (x - x0) / (x1 - x0));
	endfunction

	task automatic complete_run;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ======================================
	// Watchdog, far beyond the roughly 140 cycles needed
	initial begin
		#2000000;
		n_mismatch++;
		complete_run();
	end

	// ======================================
	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		rd_reg(8'h60);
		chk("point_a", 32'h1770, got);
		rd_reg(8'h64);
		chk("point_b", 32'h0FA0, got);
		rd_reg(8'h68);
		chk("point_c1", 32'hFFFF, got);
		rd_reg(8'h18);
		chk("set2_band", 32'hFFFF, got);
		pb1 = 16'(1 + $unsigned($random(seed)) % 10000);
		pb2 = 16'(1 + $unsigned($random(seed)) % 10000);
		pbn = 16'(1 + $unsigned($random(seed)) % 10000);
		tdb = 16'(1 + $unsigned($random(seed)) % 1000);
		tin = 16'(1 + $unsigned($random(seed)) % 36000);
		wr_reg(8'h18, pb1);
		wr_reg(8'h30, pb2);
		wr_reg(8'h0C, pbn);
		wr_reg(8'h08, tdb);
		wr_reg(8'h40, tin);
		// Walk all four sets, both polarities; inputs move only at a rising edge
		for (int s = 0; s < 4; s++) begin
			@(posedge sys_clk);
			{lb, la} <= 2'(s);
			below <= 1'b0;
			settle(5);
			chk("active_set", 32'(s), 32'(act));
			exp_pb = (s == 1) ? pb1 : (s == 2) ? pb2 : 16'h03E8;
			chk("pos_band", 32'(exp_pb), 32'(coef.coef.pb));
			chk("pos_deriv", 32'(tdb), 32'(coef.coef.td));
			chk("loop_gain", 32'(exp_loop(32'h3E8, 32'(exp_pb))), 32'(coef.loop_gain));
			@(posedge sys_clk);
			below <= 1'b1;
			settle(2);
			// Fourth set falls through its own positive value to the first negative one
			exp_neg = ((s == 0) || (s == 3)) ? pbn : exp_pb;
			chk("neg_band", 32'(exp_neg), 32'(coef.coef.pb));
			exp_g = (s == 2) ? 32'(tin) : 32'hFFFF;
			chk("neg_integral", exp_g, 32'(coef.coef.ti));
		end
		// Refused breakpoint order raises the masked interrupt
		wr_reg(8'h88, 16'h0001);
		wr_reg(8'h6C, 16'h1400);
		wr_reg(8'h68, 16'h1300);
		settle(1);
		chk("irq_raised", 32'h1, 32'(irq));
		rd_reg(8'h68);
		chk("c1_kept", 32'hFFFF, got);
		// Set and polarity events of the walk are still held beside the error
		rd_reg(8'h84);
		chk("status_bits", 32'h7, got);
		settle(1);
		chk("irq_cleared", 32'h0, 32'(irq));
		// Gain switching needs both inner points
		wr_reg(8'h70, 16'h07D0);
		wr_reg(8'h6C, 16'hFFFF);
		dev <= 16'h1770;
		settle(3);
		chk("gain_off", 32'h03E8, 32'(coef.gain_g));
		wr_reg(8'h68, 16'h1500);
		wr_reg(8'h6C, 16'h1400);
		settle(3);
		chk("gain_a", 32'h07D0, 32'(coef.gain_g));
		wr_reg(8'h68, 16'h1400);
		wr_reg(8'h78, 16'h01F4);
		wr_reg(8'h7C, 16'h0320);
		dev <= 16'h1400;
		settle(3);
		chk("gain_equal", 32'h0320, 32'(coef.gain_g));
		@(posedge sys_clk);
		dev <= 16'h0FA0;
		settle(3);
		chk("gain_b_unity", 32'h03E8, 32'(coef.gain_g));
		// Split the inner points again: band D, then both slopes
		wr_reg(8'h68, 16'h1500);
		wr_reg(8'h80, 16'h0BB8);
		dev <= 16'h1480;
		settle(3);
		chk("gain_d", 32'h0BB8, 32'(coef.gain_g));
		@(posedge sys_clk);
		dev <= 16'h1600;
		settle(2);
		exp_g = exp_lerp(32'h1600, 32'h1500, 32'h1770, 32'h01F4, 32'h07D0);
		chk("gain_upper", exp_g, 32'(coef.gain_g));
		@(posedge sys_clk);
		dev <= 16'h1000;
		settle(2);
		// Falling slope from unity at B down to gain C2
		exp_g = exp_lerp(32'h1000, 32'h0FA0, 32'h1400, 32'h03E8, 32'h0320);
		chk("gain_lower", exp_g, 32'(coef.gain_g));
		// Out-of-range settings are refused and flag the interrupt again
		wr_reg(8'h74, 16'h0000);
		rd_reg(8'h74);
		chk("gain_b_kept", 32'hFFFF, got);
		wr_reg(8'h18, 16'h2711);
		rd_reg(8'h18);
		chk("band_kept", 32'(pb1), got);
		wr_reg(8'h60, 16'h0FA0);
		rd_reg(8'h60);
		chk("point_a_kept", 32'h1770, got);
		chk("irq_again", 32'h1, 32'(irq));
		complete_run();
	end
endmodule
